// ===== hw/dbl_defs.svh
// offsets, field positions, reset values and limits of the burst latency core
`ifndef DBL_DEFS_SVH
`define DBL_DEFS_SVH
`define DBL_OFS_MODE 8'h00
`define DBL_OFS_LAT 8'h04
`define DBL_OFS_STAT 8'h08
`define DBL_MODE_BURST_LSB 0
`define DBL_MODE_PAR_EN 2
`define DBL_MODE_CAL_EN 3
`define DBL_MODE_CAL_LSB 4
`define DBL_LAT_RCL_LSB 0
`define DBL_LAT_WCL_LSB 8
`define DBL_LAT_ADD_LSB 16
`define DBL_LAT_PAR_LSB 24
`define DBL_STAT_DLL 0
`define DBL_STAT_WUNL 1
`define DBL_STAT_RBUSY 2
`define DBL_STAT_WBUSY 3
`define DBL_STAT_RCNT_LSB 8
`define DBL_STAT_WCNT_LSB 16
`define DBL_RST_BURST 2'h1
`define DBL_RST_CAL 4'h3
`define DBL_RST_RCL 5'h0B
`define DBL_RST_WCL 5'h09
`define DBL_RST_ADD 5'h00
`define DBL_RST_PAR 4'h4
`define DBL_BEATS_FULL 4'h8
`define DBL_BEATS_CHOP 4'h4
`define DBL_MIN_LAT 7'h02
`endif

// ===== hw/dbl_pkg.sv
// types shared by the burst latency core
package dbl_pkg;
  typedef enum logic [1:0] {
    DBL_BURST_FIXED8 = 2'h0,
    DBL_BURST_OTF = 2'h1,
    DBL_BURST_FIXED4 = 2'h2,
    DBL_BURST_RSVD = 2'h3
  } dbl_burst_e;
  typedef enum logic {
    DBL_CAL_IDLE,
    DBL_CAL_WAIT
  } dbl_cal_e;
endpackage

// ===== hw/dbl_delay_line.sv
// tapped shift register that delays command tokens by a chosen count
`timescale 1ns/1ps
module dbl_delay_line #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 64,
  parameter int SELW = 6
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // token in and tapped token out
  input wire logic [WIDTH-1:0] din,
  input wire logic [SELW-1:0] sel,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage_q [DEPTH];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_q[i] <= '0;
      end
    end else begin
      stage_q[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign dout = stage_q[sel];
endmodule

// ===== hw/dbl_burst_core.sv
// burst length and latency scheduling core with an ahb-lite register slave
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "dbl_defs.svh"
module dbl_burst_core
  import dbl_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int SELW = 6
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // command pins
  input wire logic cs_n,
  input wire logic cmd_col,
  input wire logic cmd_wr,
  input wire logic addr_a12,
  input wire logic addr_a10,
  input wire logic odt_in,
  input wire logic dll_locked,
  // burst and termination outputs
  output logic rd_beat,
  output logic wr_beat,
  output logic bank_close,
  output logic odt_out
);
  localparam int NPIN = 7;

  // pin synchronisers
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic cs_n_s, col_s, wr_s, a12_s, a10_s, odt_s, dll_s;

  assign pin_raw = {dll_locked, odt_in, addr_a10, addr_a12, cmd_wr, cmd_col,
                    cs_n};

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      localparam logic RV = (g == 0) ? 1'b1 : 1'b0;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_q[g] <= RV;
          sync2_q[g] <= RV;
        end else begin
          sync1_q[g] <= pin_raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  assign {dll_s, odt_s, a10_s, a12_s, wr_s, col_s, cs_n_s} = sync2_q;

  // configuration and status registers
  logic [1:0] burst_q;
  logic par_en_q, cal_en_q;
  logic [3:0] cal_q;
  logic [4:0] rcl_q, wcl_q, add_lat_q;
  logic [3:0] par_lat_q;
  logic wunl_q;
  logic [7:0] rcnt_q, wcnt_q;

  // ahb address phase capture
  logic ap_valid, dp_wr_q;
  logic [7:0] dp_addr_q;
  logic [31:0] rd_mux;
  logic mode_wr, lat_wr, stat_wr;

  assign ap_valid = hsel && hready && htrans[1];
  assign mode_wr = dp_wr_q && (dp_addr_q == `DBL_OFS_MODE);
  assign lat_wr = dp_wr_q && (dp_addr_q == `DBL_OFS_LAT);
  assign stat_wr = dp_wr_q && (dp_addr_q == `DBL_OFS_STAT);

  logic rbusy, wbusy;
  logic [31:0] mode_word, lat_word, stat_word;
  assign mode_word = {24'h0, cal_q, cal_en_q, par_en_q, burst_q};
  assign lat_word = {4'h0, par_lat_q, 3'h0, add_lat_q, 3'h0, wcl_q, 3'h0,
                     rcl_q};
  assign stat_word = {8'h0, wcnt_q, rcnt_q, 4'h0, wbusy, rbusy, wunl_q,
                      dll_s};
  assign rd_mux = (haddr == `DBL_OFS_MODE) ? mode_word :
                  (haddr == `DBL_OFS_LAT) ? lat_word :
                  (haddr == `DBL_OFS_STAT) ? stat_word : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      dp_wr_q <= ap_valid && hwrite;
      dp_addr_q <= haddr;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap_valid && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_q <= `DBL_RST_BURST;
      par_en_q <= 1'b0;
      cal_en_q <= 1'b0;
      cal_q <= `DBL_RST_CAL;
      rcl_q <= `DBL_RST_RCL;
      wcl_q <= `DBL_RST_WCL;
      add_lat_q <= `DBL_RST_ADD;
      par_lat_q <= `DBL_RST_PAR;
    end else begin
      if (mode_wr) begin
        burst_q <= hwdata[`DBL_MODE_BURST_LSB +: 2];
        par_en_q <= hwdata[`DBL_MODE_PAR_EN];
        cal_en_q <= hwdata[`DBL_MODE_CAL_EN];
        cal_q <= hwdata[`DBL_MODE_CAL_LSB +: 4];
      end
      if (lat_wr) begin
        rcl_q <= hwdata[`DBL_LAT_RCL_LSB +: 5];
        wcl_q <= hwdata[`DBL_LAT_WCL_LSB +: 5];
        add_lat_q <= hwdata[`DBL_LAT_ADD_LSB +: 5];
        par_lat_q <= hwdata[`DBL_LAT_PAR_LSB +: 4];
      end
    end
  end

  // command capture, direct or delayed after chip select
  dbl_cal_e cal_st_q;
  logic [3:0] cal_cnt_q;
  logic cs_prev_q;
  logic cs_fall, cal_hit, cmd_take;

  assign cs_fall = cs_prev_q && !cs_n_s;
  assign cal_hit = (cal_st_q == DBL_CAL_WAIT) && (cal_cnt_q == cal_q);
  // address is sampled cal clocks after select, latency counts from there
  assign cmd_take = cal_en_q ? (cal_hit && col_s) : (!cs_n_s && col_s);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_st_q <= DBL_CAL_IDLE;
      cal_cnt_q <= 4'h0;
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_n_s;
      unique case (cal_st_q)
        DBL_CAL_IDLE: begin
          if (cal_en_q && cs_fall) begin
            cal_st_q <= DBL_CAL_WAIT;
            cal_cnt_q <= 4'h1;
          end
        end
        DBL_CAL_WAIT: begin
          if (cal_hit || !cal_en_q) begin
            cal_st_q <= DBL_CAL_IDLE;
          end
          cal_cnt_q <= cal_cnt_q + 4'h1;
        end
      endcase
    end
  end

  // burst length selection
  logic chop;
  assign chop = (burst_q == DBL_BURST_FIXED4) ||
                ((burst_q == DBL_BURST_OTF) && !a12_s);

  // latency sums; parity latency only counts while checking is on
  function automatic logic [SELW-1:0] tap_of(input logic [4:0] col,
                                            input logic [4:0] add,
                                            input logic [3:0] par,
                                            input logic pen);
    logic [6:0] sum;
    sum = 7'(col) + 7'(add) + (pen ? 7'(par) : 7'h0);
    if (sum < `DBL_MIN_LAT) begin
      sum = `DBL_MIN_LAT;
    end
    if (sum - `DBL_MIN_LAT > 7'(DEPTH - 1)) begin
      tap_of = SELW'(DEPTH - 1);
    end else begin
      tap_of = SELW'(sum - `DBL_MIN_LAT);
    end
  endfunction

  logic [SELW-1:0] rd_sel, wr_sel;
  assign rd_sel = tap_of(rcl_q, add_lat_q, par_lat_q, par_en_q);
  assign wr_sel = tap_of(wcl_q, add_lat_q, par_lat_q, par_en_q);

  // tokens are {autoclose, chop, valid}
  logic [2:0] tok_in [2];
  logic [2:0] tok_out [2];
  logic [SELW-1:0] sel [2];
  logic [3:0] cnt_q [2];
  logic [1:0] ac_q;
  logic [1:0] beat_d;
  logic [1:0] done;

  assign tok_in[0] = {1'b0, chop, cmd_take && !wr_s};
  assign tok_in[1] = {a10_s, chop, cmd_take && wr_s};
  assign sel[0] = rd_sel;
  assign sel[1] = wr_sel;

  generate
    for (g = 0; g < 2; g++) begin : g_dir
      dbl_delay_line #(
        .WIDTH(3),
        .DEPTH(DEPTH),
        .SELW(SELW)
      ) u_dl (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(tok_in[g]),
        .sel(sel[g]),
        .dout(tok_out[g])
      );
      assign done[g] = (cnt_q[g] == 4'h1);
      // decoded, so the output flop is the only stage after the tap
      assign beat_d[g] = tok_out[g][0] || (cnt_q[g] > 4'h1);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_q[g] <= 4'h0;
          ac_q[g] <= 1'b0;
        end else begin
          if (tok_out[g][0]) begin
            cnt_q[g] <= tok_out[g][1] ? `DBL_BEATS_CHOP : `DBL_BEATS_FULL;
            ac_q[g] <= tok_out[g][2];
          end else if (cnt_q[g] != 4'h0) begin
            cnt_q[g] <= cnt_q[g] - 4'h1;
          end
        end
      end
    end
  endgenerate

  assign rbusy = (cnt_q[0] != 4'h0);
  assign wbusy = (cnt_q[1] != 4'h0);

  // outputs; write beats suppressed while the loop is unlocked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_beat <= 1'b0;
      wr_beat <= 1'b0;
      bank_close <= 1'b0;
      odt_out <= 1'b0;
    end else begin
      rd_beat <= beat_d[0];
      wr_beat <= beat_d[1] && dll_s;
      bank_close <= done[1] && ac_q[1];
      // fixed path, independent of cs-to-command mode
      odt_out <= odt_s;
    end
  end

  // status: sticky unlocked-write flag, set wins over clear
  logic wunl_set;
  assign wunl_set = beat_d[1] && !dll_s;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wunl_q <= 1'b0;
      rcnt_q <= 8'h00;
      wcnt_q <= 8'h00;
    end else begin
      if (wunl_set) begin
        wunl_q <= 1'b1;
      end else if (stat_wr && hwdata[`DBL_STAT_WUNL]) begin
        wunl_q <= 1'b0;
      end
      if (cmd_take && !wr_s) begin
        rcnt_q <= rcnt_q + 8'h01;
      end
      if (cmd_take && wr_s) begin
        wcnt_q <= wcnt_q + 8'h01;
      end
    end
  end
endmodule

// ===== dv/dbl_burst_chk.sv
// assertions on the burst latency core ports
`timescale 1ns/1ps
module dbl_burst_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pins and outputs
  input wire logic cs_n,
  input wire logic cmd_col,
  input wire logic odt_in,
  input wire logic dll_locked,
  input wire logic rd_beat,
  input wire logic wr_beat,
  input wire logic bank_close,
  input wire logic odt_out
);
  logic [6:0] quiet_q;
  // saturates so a long idle spell cannot wrap back into range
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      quiet_q <= 7'h00;
    else if (!cs_n || cmd_col)
      quiet_q <= 7'h00;
    else if (quiet_q != 7'h7F)
      quiet_q <= quiet_q + 7'h01;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_odt_fixed_delay: assert property ($past(hresetn, 3) |->
    odt_out == $past(odt_in, 3)) else $error("odt delay changed");
  a_rd_min_four: assert property ($rose(rd_beat) |-> rd_beat[*4])
    else $error("read burst under four beats");
  a_wr_min_four: assert property ($rose(wr_beat) |-> wr_beat[*4])
    else $error("write burst under four beats");
  a_rd_max_eight: assert property (rd_beat[*8] |=> !rd_beat)
    else $error("read burst over eight beats");
  a_wr_max_eight: assert property (wr_beat[*8] |=> !wr_beat)
    else $error("write burst over eight beats");
  a_unlock_no_wr: assert property (!dll_locked[*4] |=> !wr_beat)
    else $error("write beat while unlocked");
  a_close_one_cycle: assert property (bank_close |=> !bank_close)
    else $error("bank close wider than one cycle");
  a_close_after_wr: assert property (bank_close |-> $fell(wr_beat))
    else $error("bank close not after last write beat");
  a_beat_needs_cmd: assert property ((rd_beat || wr_beat) |->
    quiet_q < 7'h50) else $error("beat with no command");
  c_read: cover property ($rose(rd_beat));
  c_write: cover property ($rose(wr_beat));
  c_close: cover property (bank_close);
endmodule

// ===== dv/dbl_ctl_model.sv
// controller model driving command and termination pins
`timescale 1ns/1ps
module dbl_ctl_model (
  // clock
  input wire logic hclk,
  // command and termination pins
  output logic cs_n,
  output logic cmd_col,
  output logic cmd_wr,
  output logic addr_a12,
  output logic addr_a10,
  output logic odt_in
);
  logic [2:0] odt_q = 3'h0;
  initial begin
    cs_n = 1'b1;
    cmd_col = 1'b0;
    cmd_wr = 1'b0;
    addr_a12 = 1'b0;
    addr_a10 = 1'b0;
    odt_in = 1'b0;
  end
  // termination keeps its own pace, blind to cs-to-command mode
  always @(posedge hclk) begin
    odt_q <= odt_q + 3'h1;
    odt_in <= odt_q[2] ^ odt_q[0];
  end
  // with cs-to-command mode the command trails select by n clocks
  task automatic issue(input logic w, input logic a12, input logic a10,
    input int n);
    cs_n <= 1'b0;
    if (n > 0) begin
      @(posedge hclk);
      cs_n <= 1'b1;
      repeat (n - 1) @(posedge hclk);
    end
    cmd_col <= 1'b1;
    cmd_wr <= w;
    addr_a12 <= a12;
    addr_a10 <= a10;
    @(posedge hclk);
    // released lines flip so a stale level never looks valid
    cs_n <= 1'b1;
    cmd_col <= 1'b0;
    cmd_wr <= ~w;
    addr_a12 <= ~a12;
    addr_a10 <= ~a10;
  endtask
endmodule

// ===== dv/dbl_burst_core_tb_top.sv
// testbench top for the burst latency core
`timescale 1ns/1ps
bind dbl_burst_core dbl_burst_chk u_dbl_burst_chk (.hclk, .hresetn, .cs_n,
  .cmd_col, .odt_in, .dll_locked, .rd_beat, .wr_beat, .bank_close, .odt_out);
module dbl_burst_core_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic dll_locked = 1'b1;
  logic hreadyout, hresp, cs_n, cmd_col, cmd_wr, addr_a12, addr_a10, odt_in;
  logic rd_beat, wr_beat, bank_close, odt_out;
  logic [31:0] hrdata;
  logic [31:0] seed = 32'h5AC01FDE;
  int cyc = 0, n_errors = 0, compares = 0;
  int fld = 1, rcl = 11, wcol = 9, add_lat = 0, par_lat = 4, caln = 3;
  logic pen = 1'b0, cal = 1'b0;
  always #2 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;
  dbl_burst_core u_dbl_burst_core (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .cs_n, .cmd_col, .cmd_wr, .addr_a12, .addr_a10, .odt_in,
    .dll_locked, .rd_beat, .wr_beat, .bank_close, .odt_out);
  dbl_ctl_model u_dbl_ctl_model (.hclk, .cs_n, .cmd_col, .cmd_wr,
    .addr_a12, .addr_a10, .odt_in);
  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic int exp_lat(input logic w);
    int l;
    l = (w ? wcol : rcl) + add_lat + (pen ? par_lat : 0);
    return l < 2 ? 2 : (l > 65 ? 65 : l);
  endfunction
  function automatic int exp_beats(input logic a12);
    return (fld == 2 || (fld == 1 && !a12)) ? 4 : 8;
  endfunction
  task automatic chk(input string what, input int exp, input int got);
    compares++;
    if (exp != got) begin
      n_errors++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic chk_reg(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic cfg();
    logic [31:0] r;
    ahb(1'b1, 8'h00, {24'h0, 4'(caln), cal, pen, 2'(fld)}, r);
    ahb(1'b1, 8'h04, {4'h0, 4'(par_lat), 3'h0, 5'(add_lat), 3'h0,
      5'(wcol), 3'h0, 5'(rcl)}, r);
  endtask
  // window of 100 clocks covers the longest latency, burst and close
  task automatic run(input logic w, input logic a12, input logic a10);
    int t0, lat, len, bc, el, eb, n;
    logic b;
    n = cal ? caln : 0;
    el = exp_lat(w) + n + 3;
    eb = exp_beats(a12);
    if (w && !dll_locked) begin
      el = 0;
      eb = 0;
    end
    lat = 0;
    len = 0;
    bc = 0;
    t0 = cyc;
    u_dbl_ctl_model.issue(w, a12, a10, n);
    repeat (100) begin
      @(posedge hclk);
      b = w ? wr_beat : rd_beat;
      if (b === 1'b1 && len == 0)
        lat = cyc - t0;
      if (b === 1'b1)
        len++;
      if (bank_close === 1'b1)
        bc = cyc - t0;
    end
    chk("latency", el, lat);
    chk("beats", eb, len);
    chk("close", (w && a10 && eb > 0) ? el + eb : 0, bc);
  endtask
  task automatic end_of_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
  initial begin
    logic [31:0] r;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0, r);
    chk_reg("mode", 32'h00000031, r);
    ahb(1'b0, 8'h04, 32'h0, r);
    chk_reg("lat", 32'h0400090B, r);
    ahb(1'b1, 8'h0C, 32'hFFFFFFFF, r);
    ahb(1'b0, 8'h0C, 32'h0, r);
    chk_reg("unmapped", 32'h0, r);
    $display("test registers done");
    pen = 1'b1;
    cfg();
    run(1'b0, 1'b1, 1'b0);
    run(1'b1, 1'b1, 1'b1);
    run(1'b1, 1'b1, 1'b0);
    $display("test parity done");
    for (int f = 0; f < 3; f++) begin
      fld = f;
      cfg();
      for (int a = 0; a < 4; a++)
        run(a[0], a[1], 1'b0);
    end
    $display("test burst modes done");
    dll_locked <= 1'b0;
    repeat (6) @(posedge hclk);
    run(1'b1, 1'b1, 1'b0);
    run(1'b0, 1'b1, 1'b0);
    dll_locked <= 1'b1;
    repeat (6) @(posedge hclk);
    ahb(1'b0, 8'h08, 32'h0, r);
    chk_reg("stat", 32'h00090803, r);
    ahb(1'b1, 8'h08, 32'h00000002, r);
    ahb(1'b0, 8'h08, 32'h0, r);
    chk_reg("stat clear", 32'h00090801, r);
    chk_reg("resp", 32'h0, {31'h0, hresp});
    $display("test unlock done");
    cal = 1'b1;
    for (caln = 3; caln < 5; caln++) begin
      cfg();
      run(1'b0, 1'b1, 1'b0);
    end
    cal = 1'b0;
    $display("test cs latency done");
    repeat (16) begin
      r = rnd();
      rcl = 5 + r[3:0];
      wcol = 6 + r[7:4];
      add_lat = r[11:8];
      par_lat = r[15:12];
      pen = r[16];
      fld = r[18:17] % 3;
      cfg();
      run(r[19], r[20], r[21]);
    end
    $display("test random done");
    end_of_test();
  end
endmodule
